// ==== lcd_cfg_pkg.sv ====
// Register map, field layout and output carriers of the LCD drive configuration block
package lcd_cfg_pkg;
  // Byte addresses of the word registers
  localparam logic [11:0] DRIVE_CONTROL_ADDR   = 12'h000;
  localparam logic [11:0] CHARGE_PUMP_ADDR     = 12'h004;
  localparam logic [11:0] DRIVE_PHASE_ADDR     = 12'h008;
  localparam logic [11:0] REF_LADDER_ADDR      = 12'h00C;
  localparam logic [11:0] SEG_ENABLE_BASE_ADDR = 12'h010;
  localparam logic [11:0] PIXEL_BASE_ADDR      = 12'h040;
  localparam int          SEG_REG_COUNT        = 4;
  localparam int          PIXEL_REG_COUNT      = 32;
  localparam logic [15:0] REG_RESET            = 16'h0000;
  // Drive control fields
  localparam int DRV_ENABLE_BIT   = 15;
  localparam int DRV_WFAIL_BIT    = 5;
  localparam int DRV_CLKSRC_LSB   = 3;
  localparam int DRV_COMMONS_LSB  = 0;
  // Charge pump fields
  localparam int PUMP_ON_BIT      = 15;
  localparam int PUMP_CLK_LSB     = 0;
  // Phase register fields
  localparam int PH_WAVE_BIT      = 7;
  localparam int PH_HALF_BIAS_BIT = 6;
  localparam int PH_ACTIVE_BIT    = 5;
  localparam int PH_WALLOW_BIT    = 4;
  localparam int PH_DIV_LSB       = 0;
  // Reference ladder fields
  localparam int REF_INT_ON_BIT   = 15;
  localparam int REF_CONTRAST_LSB = 11;
  localparam int REF_PIN3_BIT     = 10;
  localparam int REF_PIN2_BIT     = 9;
  localparam int REF_PIN1_BIT     = 8;
  localparam int REF_PWR_A_LSB    = 6;
  localparam int REF_PWR_B_LSB    = 4;
  localparam int REF_ALEN_LSB     = 0;
  // Writable bit masks
  localparam logic [15:0] DRV_WMASK   = 16'h801F;
  localparam logic [15:0] PUMP_WMASK  = 16'h8003;
  localparam logic [15:0] PHASE_WMASK = 16'h00CF;
  localparam logic [15:0] REF_WMASK   = 16'hBFF7;
  // Last ladder position per waveform; the ladder period is one more LCD clock
  localparam logic [4:0] LADDER_LEN_A_WAVE = 5'h0F;
  localparam logic [4:0] LADDER_LEN_B_WAVE = 5'h1F;
  // Regulator clock choices
  typedef enum logic [1:0] {
    REG_CLK_OFF  = 2'b00,
    REG_CLK_LOW_POWER_RC_OSC = 2'b01,
    REG_CLK_FRC  = 2'b10,
    REG_CLK_SECONDARY_OSCILLATOR = 2'b11
  } reg_clk_e;
  // Regulator and ladder controls toward the analog section
  typedef struct packed {
    logic       pump_on;
    logic       low_power_rc_osc;
    logic       fast_rc_osc;
    logic       secondary_oscillator;
    logic       regulator_float;
    logic       internal_reference_on;
    logic [2:0] contrast_field;
    logic       bias3_external_pin_on;
    logic       bias2_external_pin_on;
    logic       bias1_external_pin_on;
    logic [1:0] ladder_power;
    logic       ladder_in_interval_a;
  } analog_ctrl_s;
  // Waveform shape toward the electrode drivers
  typedef struct packed {
    logic       waveform_kind;
    logic       half_bias;
    logic       static_bias;
    logic       phase;
    logic [7:0] common_drive;
  } wave_ctrl_s;
endpackage : lcd_cfg_pkg

// ==== lcd_drive_config_regs.sv ====
// APB register block and frame timing of the segment LCD drive controller
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Pump bit makes top voltage internally
// R2 - Regulator clock code picks oscillator; 00 floats
// R3 - Waveform bit: set frame-phase, clear common-phase
// R4 - Software keeps bias bit zero otherwise
// R5 - Commons 001/010: bias bit picks half
// R6 - Active flag reads one while driving
// R7 - Write-allow flag shows pixel write permission
// R8 - Prescaler divides LCD clock by field+1
// R9 - Segment enable hands pin to segment drive
// R10 - Four enable registers cover segments 16j+k
// R11 - Pixel bit one turns pixel on
// R12 - Pixel register x is common x/4
// R13 - Internal reference enable routes to contrast
// R14 - Contrast field sets ladder resistance sevenths
// R15 - Bias pin bits select external levels
// R16 - Interval A ladder power field
// R17 - Interval B ladder power field
// R18 - Refused pixel write sets sticky fail flag
// R19 - Commons field selects static or multiplex
// R20 - Interval length splits A and B time
// R21 - Refused pixel write keeps stored contents
module lcd_drive_config_regs (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output lcd_cfg_pkg::analog_ctrl_s      analog_ctrl,
  output lcd_cfg_pkg::wave_ctrl_s        wave_ctrl,
  output logic      [1:0]                lcd_clock_source,
  output logic      [63:0]               segment_pin_mode,
  output logic      [63:0]               segment_data
);
  import lcd_cfg_pkg::*;

  // Byte lane mask from the APB strobes
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // Stored registers
  logic [15:0] drive_control_r;                    // Enable, clock source, commons
  logic        write_fail_r;                       // Sticky refused-write flag
  logic [15:0] charge_pump_control_r;              // Pump and regulator clock
  logic [15:0] drive_phase_control_r;              // Waveform, bias, divider
  logic [15:0] reference_ladder_control_r;         // Ladder controls
  logic [15:0] seg_enable_r [SEG_REG_COUNT];       // Segment pin enables
  logic [15:0] pixel_r      [PIXEL_REG_COUNT];     // Pixel memory

  // Timing state
  logic [3:0]  presc_cnt_r;                        // Prescaler count
  logic [2:0]  com_idx_r;                          // Current common
  logic        phase_r;                            // Drive phase
  logic [4:0]  ladder_cnt_r;                       // Ladder interval position
  logic [63:0] segment_data_r;                     // Registered segment levels

  // Access decode
  wire         wr_en      = psel & penable & pwrite;
  wire [15:0]  wmask      = lane_mask(pstrb);
  wire [15:0]  wdat       = pwdata[15:0];
  wire         sel_drv    = (paddr == DRIVE_CONTROL_ADDR);
  wire         sel_pump   = (paddr == CHARGE_PUMP_ADDR);
  wire         sel_phase  = (paddr == DRIVE_PHASE_ADDR);
  wire         sel_ref    = (paddr == REF_LADDER_ADDR);
  wire [11:0]  seg_off    = paddr - SEG_ENABLE_BASE_ADDR;
  wire [11:0]  pix_off    = paddr - PIXEL_BASE_ADDR;
  wire         sel_seg    = (paddr >= SEG_ENABLE_BASE_ADDR) && (seg_off < 12'h010) && (paddr[1:0] == 2'b00);
  wire         sel_pix    = (paddr >= PIXEL_BASE_ADDR) && (pix_off < 12'h080) && (paddr[1:0] == 2'b00);
  wire [1:0]   seg_idx    = seg_off[3:2];
  wire [4:0]   pix_idx    = pix_off[6:2];
  wire         mapped     = sel_drv | sel_pump | sel_phase | sel_ref | sel_seg | sel_pix;

  // Field views
  wire         drv_enable = drive_control_r[DRV_ENABLE_BIT];
  wire [2:0]   commons    = drive_control_r[DRV_COMMONS_LSB +: 3];
  wire         wave_b     = drive_phase_control_r[PH_WAVE_BIT];
  wire         half_sel   = drive_phase_control_r[PH_HALF_BIAS_BIT];
  wire [3:0]   div_field  = drive_phase_control_r[PH_DIV_LSB +: 4];
  wire [2:0]   a_length   = reference_ladder_control_r[REF_ALEN_LSB +: 3];
  wire [1:0]   pwr_a      = reference_ladder_control_r[REF_PWR_A_LSB +: 2];
  wire [1:0]   pwr_b      = reference_ladder_control_r[REF_PWR_B_LSB +: 2];
  wire [1:0]   clk_code   = charge_pump_control_r[PUMP_CLK_LSB +: 2];

  // Timing decode
  wire         lcd_tick   = drv_enable & (presc_cnt_r == div_field); // R8
  wire         last_com   = (com_idx_r == commons);                  // R19
  wire [4:0]   ladder_top = wave_b ? LADDER_LEN_B_WAVE : LADDER_LEN_A_WAVE; // R20
  wire         in_a       = (ladder_cnt_r < {2'b00, a_length});      // R20
  // Pixel writes are refused while driving except on the last common, so a frame never tears
  wire         write_ok   = ~drv_enable | last_com;                  // R7
  wire         pix_wr     = wr_en & sel_pix;
  wire         pix_refuse = pix_wr & ~write_ok;                      // R18
  wire         fail_clear = wr_en & sel_drv & pstrb[0] & ~wdat[DRV_WFAIL_BIT];

  // Read value selection
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    if (sel_drv) begin
      rd_val = drive_control_r;
      rd_val[DRV_WFAIL_BIT] = write_fail_r;
    end else if (sel_pump) begin
      rd_val = charge_pump_control_r;
    end else if (sel_phase) begin
      rd_val = drive_phase_control_r;
      rd_val[PH_ACTIVE_BIT] = drv_enable;          // R6
      rd_val[PH_WALLOW_BIT] = write_ok;            // R7
    end else if (sel_ref) begin
      rd_val = reference_ladder_control_r;
    end else if (sel_seg) begin
      rd_val = seg_enable_r[seg_idx];
    end else if (sel_pix) begin
      rd_val = pixel_r[pix_idx];
    end
  end

  // Zero-wait slave; unmapped words answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = {16'h0000, rd_val};

  // Control registers with write masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_control_r            <= REG_RESET;
      charge_pump_control_r      <= REG_RESET;
      drive_phase_control_r      <= REG_RESET;
      reference_ladder_control_r <= REG_RESET;
    end else if (wr_en) begin
      if (sel_drv)
        drive_control_r <= (drive_control_r & ~(wmask & DRV_WMASK)) | (wdat & wmask & DRV_WMASK);
      if (sel_pump)
        charge_pump_control_r <= (charge_pump_control_r & ~(wmask & PUMP_WMASK)) | (wdat & wmask & PUMP_WMASK);
      if (sel_phase)
        drive_phase_control_r <= (drive_phase_control_r & ~(wmask & PHASE_WMASK)) | (wdat & wmask & PHASE_WMASK);
      if (sel_ref)
        reference_ladder_control_r <= (reference_ladder_control_r & ~(wmask & REF_WMASK)) | (wdat & wmask & REF_WMASK);
    end
  end

  // Sticky fail flag; a new refusal beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      write_fail_r <= 1'b0;
    else if (pix_refuse)
      write_fail_r <= 1'b1;                         // R18
    else if (fail_clear)
      write_fail_r <= 1'b0;
  end

  // Segment enable and pixel storage
  genvar g;
  generate
    for (g = 0; g < SEG_REG_COUNT; g++) begin : g_seg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          seg_enable_r[g] <= REG_RESET;
        else if (wr_en && sel_seg && seg_idx == 2'(g))
          seg_enable_r[g] <= (seg_enable_r[g] & ~wmask) | (wdat & wmask); // R10
      end
      // Bit k of register g steers segment pin 16g+k
      assign segment_pin_mode[16*g +: 16] = seg_enable_r[g]; // R9
    end
    for (g = 0; g < PIXEL_REG_COUNT; g++) begin : g_pix
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pixel_r[g] <= REG_RESET;
        else if (pix_wr && write_ok && pix_idx == 5'(g))
          pixel_r[g] <= (pixel_r[g] & ~wmask) | (wdat & wmask); // R21
      end
    end
  endgenerate

  // Prescaler: one LCD clock every field+1 bus clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      presc_cnt_r <= 4'h0;
    else if (!drv_enable || lcd_tick)
      presc_cnt_r <= 4'h0;                          // R8
    else
      presc_cnt_r <= presc_cnt_r + 4'h1;
  end

  // Common and phase sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_idx_r <= 3'h0;
      phase_r   <= 1'b0;
    end else if (!drv_enable) begin
      com_idx_r <= 3'h0;
      phase_r   <= 1'b0;
    end else if (lcd_tick) begin
      if (!wave_b) begin
        // Both phases inside each common period
        phase_r <= ~phase_r;                        // R3
        if (phase_r)
          com_idx_r <= last_com ? 3'h0 : com_idx_r + 3'h1; // R19
      end else begin
        // Phase flips only when the frame wraps
        com_idx_r <= last_com ? 3'h0 : com_idx_r + 3'h1; // R19
        if (last_com)
          phase_r <= ~phase_r;                      // R3
      end
    end
  end

  // Ladder interval position within 16 or 32 LCD clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ladder_cnt_r <= 5'h00;
    else if (!drv_enable)
      ladder_cnt_r <= 5'h00;
    else if (lcd_tick)
      ladder_cnt_r <= (ladder_cnt_r >= ladder_top) ? 5'h00 : ladder_cnt_r + 5'h01; // R20
  end

  // Segment levels for the common now driven
  logic [63:0] row_bits;
  always_comb begin
    row_bits = 64'h0;
    for (int k = 0; k < 4; k++)
      row_bits[16*k +: 16] = pixel_r[{com_idx_r, 2'(k)}]; // R12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      segment_data_r <= 64'h0;
    else
      segment_data_r <= drv_enable ? (row_bits & segment_pin_mode) : 64'h0; // R11
  end
  assign segment_data = segment_data_r;

  // Waveform outputs
  wire mux_low = (commons == 3'b001) || (commons == 3'b010);
  assign wave_ctrl.waveform_kind = wave_b;                          // R3
  // Bias bit ignored where only static or third bias is legal
  assign wave_ctrl.half_bias     = mux_low & half_sel;              // R5
  assign wave_ctrl.static_bias   = (commons == 3'b000);             // R4
  assign wave_ctrl.phase         = phase_r;
  assign wave_ctrl.common_drive  = drv_enable ? (8'h01 << com_idx_r) : 8'h00; // R19

  // Analog section controls
  assign analog_ctrl.pump_on               = charge_pump_control_r[PUMP_ON_BIT]; // R1
  assign analog_ctrl.low_power_rc_osc      = (clk_code == REG_CLK_LOW_POWER_RC_OSC);          // R2
  assign analog_ctrl.fast_rc_osc           = (clk_code == REG_CLK_FRC);           // R2
  assign analog_ctrl.secondary_oscillator  = (clk_code == REG_CLK_SECONDARY_OSCILLATOR);          // R2
  assign analog_ctrl.regulator_float       = (clk_code == REG_CLK_OFF);           // R2
  assign analog_ctrl.internal_reference_on = reference_ladder_control_r[REF_INT_ON_BIT]; // R13
  assign analog_ctrl.contrast_field        = reference_ladder_control_r[REF_CONTRAST_LSB +: 3]; // R14
  assign analog_ctrl.bias3_external_pin_on = reference_ladder_control_r[REF_PIN3_BIT]; // R15
  assign analog_ctrl.bias2_external_pin_on = reference_ladder_control_r[REF_PIN2_BIT]; // R15
  assign analog_ctrl.bias1_external_pin_on = reference_ladder_control_r[REF_PIN1_BIT]; // R15
  // Power code follows the interval; zero length stays in B
  assign analog_ctrl.ladder_power          = in_a ? pwr_a : pwr_b; // R16 R17
  assign analog_ctrl.ladder_in_interval_a  = in_a;                 // R20
  assign lcd_clock_source                  = drive_control_r[DRV_CLKSRC_LSB +: 2];

endmodule : lcd_drive_config_regs

// ==== lcd_drive_config_regs_properties.sv ====
// Port-level concurrent checks for the LCD drive configuration block
`timescale 1ns/10ps
module lcd_drive_config_regs_checker (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire lcd_cfg_pkg::analog_ctrl_s analog_ctrl,
  input wire lcd_cfg_pkg::wave_ctrl_s   wave_ctrl,
  input wire logic [1:0]               lcd_clock_source,
  input wire logic [63:0]              segment_pin_mode,
  input wire logic [63:0]              segment_data
);
  import lcd_cfg_pkg::*;
  // Completed write and phase-register read on the bus
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic rd_phase = psel && penable && !pwrite && (paddr == DRIVE_PHASE_ADDR);
  // One domain only, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pump;
    wr_done && paddr == CHARGE_PUMP_ADDR && pstrb[1] |=> analog_ctrl.pump_on == $past(pwdata[15]);
  endproperty
  a_pump: assert property (p_pump) else $error("pump enable not taken from write");
  property p_regclk;
    analog_ctrl.regulator_float == !(analog_ctrl.low_power_rc_osc || analog_ctrl.fast_rc_osc
      || analog_ctrl.secondary_oscillator) && $onehot0({analog_ctrl.low_power_rc_osc,
      analog_ctrl.fast_rc_osc, analog_ctrl.secondary_oscillator});
  endproperty
  a_regclk: assert property (p_regclk) else $error("regulator clock decode broken");
  property p_wave;
    wr_done && paddr == DRIVE_PHASE_ADDR && pstrb[0] |=> wave_ctrl.waveform_kind == $past(pwdata[7]);
  endproperty
  a_wave: assert property (p_wave) else $error("waveform kind not taken from write");
  property p_bias;
    wave_ctrl.half_bias |-> !wave_ctrl.static_bias && $onehot0(wave_ctrl.common_drive);
  endproperty
  a_bias: assert property (p_bias) else $error("half bias with static bias");
  property p_active;
    rd_phase && !prdata[5] |-> wave_ctrl.common_drive == 8'h00;
  endproperty
  a_active: assert property (p_active) else $error("inactive yet driving commons");
  property p_seg;
    wr_done && paddr == SEG_ENABLE_BASE_ADDR + 12'h004 && pstrb == 4'h3
      |=> segment_pin_mode[31:16] == $past(pwdata[15:0]);
  endproperty
  a_seg: assert property (p_seg) else $error("segment enable group one wrong");
  property p_data;
    (segment_data & ~$past(segment_pin_mode)) == 64'h0;
  endproperty
  a_data: assert property (p_data) else $error("data on a pin not in segment mode");
  property p_ref;
    wr_done && paddr == REF_LADDER_ADDR && pstrb == 4'h3 |=> {analog_ctrl.internal_reference_on,
      analog_ctrl.contrast_field, analog_ctrl.bias3_external_pin_on, analog_ctrl.bias2_external_pin_on,
      analog_ctrl.bias1_external_pin_on} == {$past(pwdata[15]), $past(pwdata[13:8])};
  endproperty
  a_ref: assert property (p_ref) else $error("reference controls not taken from write");
  property p_alen0;
    wr_done && paddr == REF_LADDER_ADDR && pstrb[0] && pwdata[2:0] == 3'h0 |-> ##2 !analog_ctrl.ladder_in_interval_a;
  endproperty
  a_alen0: assert property (p_alen0) else $error("interval A with zero length");
  c_refused: cover property (rd_phase && prdata[5] && !prdata[4]);
  c_half: cover property (wave_ctrl.half_bias && wave_ctrl.common_drive == 8'h02);
  c_in_a: cover property (analog_ctrl.ladder_in_interval_a ##1 !analog_ctrl.ladder_in_interval_a);
endmodule : lcd_drive_config_regs_checker

bind lcd_drive_config_regs lcd_drive_config_regs_checker i_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_ctrl(analog_ctrl), .wave_ctrl(wave_ctrl), .lcd_clock_source(lcd_clock_source),
  .segment_pin_mode(segment_pin_mode), .segment_data(segment_data));

// ==== lcd_panel_model.sv ====
// Glass panel model: keeps the segment row each common electrode last saw
`timescale 1ns/10ps
module lcd_panel_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  common_drive,
  input wire logic [63:0] segment_data
);
  logic [7:0]  com_q_r;    // Common live one cycle ago, since data trails it
  logic [63:0] lit_r [8];  // Row seen per common
  // Latch rows the way the electrodes meet them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_q_r <= 8'h00;
      lit_r <= '{default: 64'h0};
    end else begin
      com_q_r <= common_drive;
      for (int c = 0; c < 8; c++) begin
        if (com_q_r[c]) lit_r[c] <= segment_data;
      end
    end
  end
endmodule : lcd_panel_model

// ==== lcd_drive_config_regs_test.sv ====
// Self-checking bench for the LCD drive configuration block
`timescale 1ns/10ps
module lcd_drive_config_regs_test;
  import lcd_cfg_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [3:0]   pstrb;
  analog_ctrl_s analog_ctrl;
  wave_ctrl_s   wave_ctrl;
  logic [1:0]   lcd_clock_source;
  logic [63:0]  segment_pin_mode, segment_data;
  int           errors = 0, checks = 0, cyc = 0;
  lcd_drive_config_regs i_lcd_drive_config_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_ctrl(analog_ctrl), .wave_ctrl(wave_ctrl),
    .lcd_clock_source(lcd_clock_source), .segment_pin_mode(segment_pin_mode), .segment_data(segment_data));
  lcd_panel_model i_lcd_panel_model (.pclk(pclk), .presetn(presetn), .common_drive(wave_ctrl.common_drive),
    .segment_data(segment_data));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [32:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write edge settle before callers look at outputs
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic err);
    logic [32:0] q;
    apb(1'b0, a, 16'h0000, q);
    chk(q, {err, 16'h0000, exp});
  endtask : rd
  // Reset values, plus an unmapped word past the pixel store
  task automatic t_reset;
    rd(DRIVE_CONTROL_ADDR, 16'h0000, 1'b0);
    rd(DRIVE_PHASE_ADDR, 16'h0010, 1'b0);
    rd(REF_LADDER_ADDR, 16'h0000, 1'b0);
    rd(PIXEL_BASE_ADDR + 12'h07C, 16'h0000, 1'b0);
    rd(12'h0C0, 16'h0000, 1'b1);
    chk({analog_ctrl.regulator_float, wave_ctrl.static_bias}, 2'b11);
    $display("reset test done");
  endtask : t_reset
  // Every regulator clock code with the pump on
  task automatic t_pump;
    logic [3:0] tbl [4];
    tbl = '{4'h1, 4'h8, 4'h4, 4'h2};
    for (int i = 0; i < 4; i++) begin
      wr(CHARGE_PUMP_ADDR, 16'h8000 | 16'(i));
      rd(CHARGE_PUMP_ADDR, 16'h8000 | 16'(i), 1'b0);
      chk({analog_ctrl.pump_on, analog_ctrl.low_power_rc_osc, analog_ctrl.fast_rc_osc,
        analog_ctrl.secondary_oscillator, analog_ctrl.regulator_float}, {1'b1, tbl[i]});
    end
    $display("pump test done");
  endtask : t_pump
  // Reference ladder fields, read-as-zero bits included
  task automatic t_ref;
    wr(REF_LADDER_ADDR, 16'hFFFF);
    rd(REF_LADDER_ADDR, 16'hBFF7, 1'b0);
    wr(REF_LADDER_ADDR, 16'h1A00);
    chk({analog_ctrl.internal_reference_on, analog_ctrl.contrast_field, analog_ctrl.bias3_external_pin_on,
      analog_ctrl.bias2_external_pin_on, analog_ctrl.bias1_external_pin_on}, 7'h1A);
    $display("reference test done");
  endtask : t_ref
  // Four enable words land on segments 16j+k
  task automatic t_seg;
    logic [15:0] v [4];
    v = '{16'h0001, 16'hFFFF, 16'h8000, 16'h1234};
    for (int j = 0; j < 4; j++) wr(SEG_ENABLE_BASE_ADDR + 12'(4 * j), v[j]);
    chk(segment_pin_mode, 64'h1234_8000_FFFF_0001);
    $display("segment test done");
  endtask : t_seg
  // Drive two commons: prescale, pixel map, refused write, ladder split
  task automatic t_drive;
    logic p;
    int   n, na, np;
    wr(PIXEL_BASE_ADDR + 12'h014, 16'hA5A5);
    wr(DRIVE_PHASE_ADDR, 16'h0043);
    wr(DRIVE_CONTROL_ADDR, 16'h8001);
    chk({wave_ctrl.half_bias, wave_ctrl.static_bias}, 2'b10);
    p = wave_ctrl.phase;
    while (wave_ctrl.phase === p) @(posedge pclk);
    p = wave_ctrl.phase;
    for (n = 0; wave_ctrl.phase === p && n < 64; n++) @(posedge pclk);
    chk(n, 4);
    while (wave_ctrl.common_drive !== 8'h02) @(posedge pclk);
    while (wave_ctrl.common_drive !== 8'h01) @(posedge pclk);
    chk(i_lcd_panel_model.lit_r[1], 64'h0000_0000_A5A5_0000);
    chk(i_lcd_panel_model.lit_r[0], 64'h0);
    wr(PIXEL_BASE_ADDR + 12'h014, 16'h0000);
    rd(DRIVE_CONTROL_ADDR, 16'h8021, 1'b0);
    wr(DRIVE_PHASE_ADDR, 16'h0040);
    for (int k = 0; k < 2; k++) begin
      wr(REF_LADDER_ADDR, k ? 16'h00D0 : 16'h00D3);
      repeat (20) @(posedge pclk);
      na = 0;
      np = 0;
      repeat (32) begin
        @(posedge pclk);
        na += analog_ctrl.ladder_in_interval_a;
        np += (analog_ctrl.ladder_power === 2'b11);
      end
      chk({na, np}, k ? 64'h0 : {32'd6, 32'd6});
    end
    wr(DRIVE_PHASE_ADDR, 16'h0000);
    wr(DRIVE_CONTROL_ADDR, 16'h8000);
    rd(DRIVE_PHASE_ADDR, 16'h0030, 1'b0);
    wr(DRIVE_CONTROL_ADDR, 16'h0000);
    rd(DRIVE_CONTROL_ADDR, 16'h0000, 1'b0);
    rd(PIXEL_BASE_ADDR + 12'h014, 16'hA5A5, 1'b0);
    $display("drive test done");
  endtask : t_drive
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pump();
    t_ref();
    t_seg();
    t_drive();
    wrap_up();
  end
endmodule : lcd_drive_config_regs_test
